/* File: design/start_sync_pkg.sv */
// Constants shared by the start synchroniser and the target queue.
// Assumes one system clock at 100 MHz and an APB register bus.
package start_sync_pkg;

  // ==========================================================================
  // Register offsets (byte addresses, one aligned word each; eight words at the queue base)
  // ==========================================================================
  localparam logic [11:0] OFS_START_CONF  = 12'h008;
  localparam logic [11:0] OFS_OUT_ADD     = 12'h044;
  localparam logic [11:0] OFS_START_DELAY = 12'h04C;
  localparam logic [11:0] OFS_TARGET      = 12'h050;
  localparam logic [11:0] OFS_VEL_LIMIT   = 12'h054;
  localparam logic [11:0] OFS_PROFILE     = 12'h058;
  localparam logic [11:0] OFS_WB_MASK     = 12'h05C;
  localparam logic [11:0] OFS_IRQ_STATUS  = 12'h060;
  localparam logic [11:0] OFS_IRQ_MASK    = 12'h064;
  localparam logic [11:0] OFS_QUEUE_BASE  = 12'h0E0;

  // ==========================================================================
  // Start configuration field positions
  // ==========================================================================
  localparam int APPLY_LSB     = 0;
  localparam int TRIG_LSB      = 5;
  localparam int POL_BIT       = 9;
  localparam int IMMEDIATE_BIT = 10;
  localparam int QUEUE_EN_BIT  = 11;

  // Trigger-select bits, relative to TRIG_LSB
  localparam int TRIG_EXT     = 0;
  localparam int TRIG_TARGET  = 1;
  localparam int TRIG_SPEED   = 2;
  localparam int TRIG_COMPARE = 3;

  // Apply-select bits
  localparam int APPLY_TARGET  = 0;
  localparam int APPLY_VEL     = 1;
  localparam int APPLY_PROFILE = 2;

  // Interrupt status bits
  localparam int IRQ_START = 0;
  localparam int IRQ_EXT   = 1;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [31:0] START_CONF_RST = 32'h0000_0000;
  localparam logic [31:0] WORD_RST       = 32'h0000_0000;
  localparam logic [2:0]  PROFILE_RST    = 3'h0;

endpackage : start_sync_pkg

/* File: design/start_delay_timer.sv */
// Start delay timer: counts the start delay after a trigger is recognised.
// Assumes launch, abort and delay come from the same clock domain.
`timescale 1ns/1ps
module start_delay_timer #(
  parameter int WIDTH = 32
) (
  input  wire logic             clk_sys,  // System clock
  input  wire logic             rst_n,    // Asynchronous reset, active low
  input  wire logic             launch,   // Start counting, ignored while busy
  input  wire logic             abort,    // Drop a running count
  input  wire logic [WIDTH-1:0] delay,    // Cycles from launch to expiry
  output logic                  busy,     // Count in progress
  output logic                  expire    // One-cycle pulse at expiry
);

  initial
  begin
    if (WIDTH < 2) $error("start_delay_timer: WIDTH below 2");
  end

  logic [WIDTH-1:0] count_q;

  // ==========================================================================
  // Countdown; a zero delay expires in the launch cycle
  // ==========================================================================
  assign expire = (busy && !abort && count_q <= WIDTH'(1))
                  || (!busy && launch && !abort && delay == '0);

  // Launch while busy is ignored so a running delay is never restarted
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy    <= 1'b0;
      count_q <= '0;
    end
    else if (abort || expire)
    begin
      busy <= 1'b0;
    end
    else if (busy)
    begin
      count_q <= count_q - WIDTH'(1);
    end
    else if (launch)
    begin
      busy    <= 1'b1;
      count_q <= delay;
    end
  end

endmodule : start_delay_timer

/* File: design/target_queue.sv */
// Eight-entry target queue with shift and write-back on each start.
// Assumes loads and advances are never requested in the same cycle.
`timescale 1ns/1ps
module target_queue #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 32
) (
  input  wire logic             clk_sys,     // System clock
  input  wire logic             rst_n,       // Asynchronous reset, active low
  input  wire logic             loadEn,      // Host write of one entry
  input  wire logic [2:0]       loadIdx,     // Entry written by host
  input  wire logic [WIDTH-1:0] loadData,    // Host write data
  input  wire logic             advance,     // Shift and write back
  input  wire logic [DEPTH-1:0] wbMask,      // Entries to refill
  input  wire logic [WIDTH-1:0] wbValue,     // Currently valid target
  input  wire logic [2:0]       readIdx,     // Entry to read
  output logic      [WIDTH-1:0] head,        // Entry zero
  output logic      [WIDTH-1:0] readData     // Selected entry
);

  initial
  begin
    if (DEPTH != 8) $error("target_queue: DEPTH must be 8");
  end

  logic [WIDTH-1:0] entry_q [DEPTH];

  assign head     = entry_q[0];
  assign readData = entry_q[readIdx];

  // ==========================================================================
  // Entry storage; last entry holds on shift, write-back wins over shift
  // ==========================================================================
  for (genvar n = 0; n < DEPTH; n++)
  begin : g_entry
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
      if (!rst_n)
        entry_q[n] <= '0;
      else if (advance && wbMask[n])
        entry_q[n] <= wbValue;
      else if (advance)
        entry_q[n] <= entry_q[(n == DEPTH-1) ? n : n+1];
      else if (loadEn && loadIdx == 3'(n))
        entry_q[n] <= loadData;
    end
  end

endmodule : target_queue

/* File: design/start_sync.sv */
// Start synchroniser with deferred parameter writes and target queue.
// Assumes an APB master on clk_sys and event inputs synchronous to clk_sys.
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
module start_sync #(
  parameter int QUEUE_DEPTH = 8
) (
  input  wire logic        clk_sys,        // System clock, 100 MHz
  input  wire logic        rst_n,          // Asynchronous reset, active low
  input  wire logic        psel,           // APB select
  input  wire logic        penable,        // APB access phase
  input  wire logic        pwrite,         // APB direction
  input  wire logic [11:0] paddr,          // APB byte address
  input  wire logic [31:0] pwdata,         // APB write data
  output logic      [31:0] prdata,         // APB read data
  output logic             pready,         // APB ready
  output logic             pslverr,        // APB error, unmapped address
  input  wire logic        startIn,        // Sync pin input level
  output logic             startOut,       // Sync pin output level
  output logic             startOe,        // Sync pin output enable
  input  wire logic        targetArrived,  // Target-arrived event pulse
  input  wire logic        speedArrived,   // Speed-arrived event pulse
  input  wire logic [31:0] actualPosition, // Actual position
  input  wire logic [31:0] comparePosition,// Compare position
  output logic      [31:0] targetPosition, // Active target position
  output logic      [31:0] velocityLimit,  // Active velocity limit
  output logic      [2:0]  rampProfile,    // Active ramp profile select
  output logic             rampStart,      // Pulse: begin positioning ramp
  output logic             irq             // Level interrupt
);

  initial
  begin
    if (QUEUE_DEPTH != 8) $error("start_sync: QUEUE_DEPTH must be 8");
  end

  logic [31:0] startConf_q, outAdd_q, startDelay_q;
  logic [31:0] pendTarget_q, pendVel_q;
  logic [2:0]  pendProfile_q;
  logic        newTarget_q, pendVelV_q, pendProfV_q;
  logic [7:0]  wbMask_q;
  logic [1:0]  irqStat_q, irqMask_q;
  logic        pinDly_q, cmpDly_q, extLaunch_q;
  logic [31:0] outCnt_q;
  logic        outAct_q;

  logic [2:0]  applySel;
  logic [3:0]  trigSel;
  logic        polarity, immediate, queueEn;
  logic        wrEn, rdEn, mapped;
  logic        pinActive, extPulse, cmpMatch, cmpEvent;
  logic        timerBusy, timerExpire, timerLaunch, timerAbort;
  logic        intStart, evtLaunch, extToTimer;
  logic [31:0] queueHead, queueRd;

  assign applySel  = startConf_q[start_sync_pkg::APPLY_LSB +: 3];
  assign trigSel   = startConf_q[start_sync_pkg::TRIG_LSB +: 4];
  assign polarity  = startConf_q[start_sync_pkg::POL_BIT];
  assign immediate = startConf_q[start_sync_pkg::IMMEDIATE_BIT];
  assign queueEn   = startConf_q[start_sync_pkg::QUEUE_EN_BIT];

  // ==========================================================================
  // APB slave: zero wait states, writes land at the completing edge only
  // ==========================================================================
  assign pready = 1'b1;
  assign wrEn   = psel && penable && pwrite;
  assign rdEn   = psel && penable && !pwrite;
  assign mapped = paddr inside {start_sync_pkg::OFS_START_CONF, start_sync_pkg::OFS_OUT_ADD,
                  start_sync_pkg::OFS_START_DELAY, start_sync_pkg::OFS_TARGET,
                  start_sync_pkg::OFS_VEL_LIMIT, start_sync_pkg::OFS_PROFILE,
                  start_sync_pkg::OFS_WB_MASK, start_sync_pkg::OFS_IRQ_STATUS,
                  start_sync_pkg::OFS_IRQ_MASK}
                  || paddr[11:5] == start_sync_pkg::OFS_QUEUE_BASE[11:5];
  assign pslverr = psel && penable && !mapped;

  // Read mux
  always_comb
  begin
    prdata = 32'h0000_0000;
    if (rdEn)
    begin
      case (paddr)
        start_sync_pkg::OFS_START_CONF:  prdata = startConf_q;
        start_sync_pkg::OFS_OUT_ADD:     prdata = outAdd_q;
        start_sync_pkg::OFS_START_DELAY: prdata = startDelay_q;
        start_sync_pkg::OFS_TARGET:      prdata = targetPosition;
        start_sync_pkg::OFS_VEL_LIMIT:   prdata = velocityLimit;
        start_sync_pkg::OFS_PROFILE:     prdata = {29'h0, rampProfile};
        start_sync_pkg::OFS_WB_MASK:     prdata = {24'h0, wbMask_q};
        start_sync_pkg::OFS_IRQ_STATUS:  prdata = {30'h0, irqStat_q};
        start_sync_pkg::OFS_IRQ_MASK:    prdata = {30'h0, irqMask_q};
        default:
          if (paddr[11:5] == start_sync_pkg::OFS_QUEUE_BASE[11:5]) prdata = queueRd;
      endcase
    end
  end

  // Plain configuration registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      startConf_q  <= start_sync_pkg::START_CONF_RST;
      outAdd_q     <= start_sync_pkg::WORD_RST;
      startDelay_q <= start_sync_pkg::WORD_RST;
      wbMask_q     <= 8'h00;
      irqMask_q    <= 2'h0;
    end
    else if (wrEn)
    begin
      case (paddr)
        start_sync_pkg::OFS_START_CONF:  startConf_q  <= pwdata;
        start_sync_pkg::OFS_OUT_ADD:     outAdd_q     <= pwdata;
        start_sync_pkg::OFS_START_DELAY: startDelay_q <= pwdata;
        start_sync_pkg::OFS_WB_MASK:     wbMask_q     <= pwdata[7:0];
        start_sync_pkg::OFS_IRQ_MASK:    irqMask_q    <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Trigger recognition
  // ==========================================================================
  // Pin taken as synchronous; an edge into the active level is the trigger
  assign pinActive = startIn ~^ polarity;
  assign cmpMatch  = actualPosition == comparePosition;
  assign extPulse  = trigSel[start_sync_pkg::TRIG_EXT] && pinActive && !pinDly_q;
  assign cmpEvent  = trigSel[start_sync_pkg::TRIG_COMPARE] && cmpMatch && !cmpDly_q;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinDly_q <= 1'b0;
      cmpDly_q <= 1'b0;
    end
    else
    begin
      pinDly_q <= pinActive;
      cmpDly_q <= cmpMatch;
    end
  end

  // Internal events launch the timer; external joins them unless prioritised
  assign evtLaunch = (trigSel[start_sync_pkg::TRIG_TARGET] && targetArrived)
                     || (trigSel[start_sync_pkg::TRIG_SPEED] && speedArrived)
                     || cmpEvent;
  assign extToTimer  = extPulse && !immediate;
  // A running timer swallows compare triggers, and external triggers unless prioritised (those abort it)
  assign timerLaunch = (applySel != 3'h0) && (evtLaunch || extToTimer);
  assign timerAbort  = immediate && extPulse;

  start_delay_timer #(
    .WIDTH (32)
  ) u_timer (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .launch  (timerLaunch),
    .abort   (timerAbort),
    .delay   (startDelay_q),
    .busy    (timerBusy),
    .expire  (timerExpire)
  );

  // Remember which source launched the running timer
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      extLaunch_q <= 1'b0;
    else if (timerLaunch && !timerBusy)
      extLaunch_q <= extToTimer;
  end

  // Internal start; apply-select zero disables generation entirely
  assign intStart = (applySel != 3'h0) && (timerExpire || timerAbort);

  // ==========================================================================
  // Deferred writes and the active parameter set
  // ==========================================================================
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pendTarget_q   <= start_sync_pkg::WORD_RST;
      pendVel_q      <= start_sync_pkg::WORD_RST;
      pendProfile_q  <= start_sync_pkg::PROFILE_RST;
      newTarget_q    <= 1'b0;
      pendVelV_q     <= 1'b0;
      pendProfV_q    <= 1'b0;
      targetPosition <= start_sync_pkg::WORD_RST;
      velocityLimit  <= start_sync_pkg::WORD_RST;
      rampProfile    <= start_sync_pkg::PROFILE_RST;
      rampStart      <= 1'b0;
    end
    else
    begin
      rampStart <= 1'b0;
      // Target: immediate, deferred, or from the queue head
      if (wrEn && paddr == start_sync_pkg::OFS_TARGET)
      begin
        if (applySel[start_sync_pkg::APPLY_TARGET])
        begin
          pendTarget_q <= pwdata;
          newTarget_q  <= 1'b1;
        end
        else
        begin
          targetPosition <= pwdata;
          rampStart      <= 1'b1;
        end
      end
      else if (intStart && applySel[start_sync_pkg::APPLY_TARGET])
      begin
        if (queueEn)
        begin
          targetPosition <= queueHead;
          rampStart      <= 1'b1;
        end
        else if (newTarget_q)
        begin
          targetPosition <= pendTarget_q;
          rampStart      <= 1'b1;
        end
        newTarget_q <= 1'b0;
      end
      // Velocity limit and profile each held until a start when their apply bit is set
      if (wrEn && paddr == start_sync_pkg::OFS_VEL_LIMIT)
      begin
        if (applySel[start_sync_pkg::APPLY_VEL])
        begin
          pendVel_q  <= pwdata;
          pendVelV_q <= 1'b1;
        end
        else
          velocityLimit <= pwdata;
      end
      else if (intStart && pendVelV_q)
      begin
        velocityLimit <= pendVel_q;
        pendVelV_q    <= 1'b0;
      end
      if (wrEn && paddr == start_sync_pkg::OFS_PROFILE)
      begin
        if (applySel[start_sync_pkg::APPLY_PROFILE])
        begin
          pendProfile_q <= pwdata[2:0];
          pendProfV_q   <= 1'b1;
        end
        else
          rampProfile <= pwdata[2:0];
      end
      else if (intStart && pendProfV_q)
      begin
        rampProfile <= pendProfile_q;
        pendProfV_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Target queue; write-back carries the target valid before this start
  // ==========================================================================
  target_queue #(
    .DEPTH (QUEUE_DEPTH),
    .WIDTH (32)
  ) u_queue (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .loadEn   (wrEn && paddr[11:5] == start_sync_pkg::OFS_QUEUE_BASE[11:5]),
    .loadIdx  (paddr[4:2]),
    .loadData (pwdata),
    .advance  (intStart && queueEn && applySel[start_sync_pkg::APPLY_TARGET]),
    .wbMask   (wbMask_q),
    .wbValue  (targetPosition),
    .readIdx  (paddr[4:2]),
    .head     (queueHead),
    .readData (queueRd)
  );

  // ==========================================================================
  // Sync pin output: extension plus one cycles at the configured polarity
  // ==========================================================================
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      outAct_q <= 1'b0;
      outCnt_q <= 32'h0000_0000;
    end
    else if (intStart)
    begin
      outAct_q <= 1'b1;
      outCnt_q <= outAdd_q;
    end
    else if (outAct_q && outCnt_q != 32'h0000_0000)
      outCnt_q <= outCnt_q - 32'h0000_0001;
    else
      outAct_q <= 1'b0;
  end

  assign startOe  = !trigSel[start_sync_pkg::TRIG_EXT];
  assign startOut = outAct_q ~^ polarity;

  // ==========================================================================
  // Interrupts: sticky status, write one to clear, set wins over clear
  // ==========================================================================
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      irqStat_q <= 2'h0;
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (i == start_sync_pkg::IRQ_START ? intStart : extPulse)
          irqStat_q[i] <= 1'b1;
        else if (wrEn && paddr == start_sync_pkg::OFS_IRQ_STATUS && pwdata[i])
          irqStat_q[i] <= 1'b0;
      end
    end
  end

  assign irq = |(irqStat_q & irqMask_q);

  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_out_length: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(outAct_q) && outAdd_q == 32'h0000_0002 |-> outAct_q [*3] ##1 !outAct_q)
    else $error("start output length wrong");
  a_out_single: assert property (@(posedge clk_sys) disable iff (!rst_n)
    intStart && outAdd_q == 32'h0000_0000 |=> outAct_q ##1 (!outAct_q || $past(intStart)))
    else $error("start output not single cycle");
  a_no_retarget: assert property (@(posedge clk_sys) disable iff (!rst_n)
    intStart && !newTarget_q && !queueEn && !wrEn |=> !rampStart)
    else $error("ramp started without new target");
  a_deferred_tgt: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wrEn && paddr == start_sync_pkg::OFS_TARGET && applySel[0] |=> $stable(targetPosition))
    else $error("deferred target applied early");
  a_vel_applied: assert property (@(posedge clk_sys) disable iff (!rst_n)
    intStart && pendVelV_q && !wrEn |=> velocityLimit == $past(pendVel_q))
    else $error("velocity not applied at start");
  a_cmp_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n)
    timerBusy && extLaunch_q && cmpEvent && !timerExpire |=> timerBusy)
    else $error("compare match disturbed timer");
  a_ext_priority: assert property (@(posedge clk_sys) disable iff (!rst_n)
    immediate && extPulse && applySel != 3'h0 |-> intStart ##1 !timerBusy)
    else $error("prioritised start not immediate");
  a_queue_head: assert property (@(posedge clk_sys) disable iff (!rst_n)
    intStart && queueEn && applySel[0] && !wrEn |=> targetPosition == $past(queueHead))
    else $error("queue head not copied");
  a_no_start_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    applySel == 3'h0 |-> !intStart)
    else $error("start generated while disabled");

  c_ext_start:   cover property (@(posedge clk_sys) disable iff (!rst_n) extPulse ##[1:4] intStart);
  c_delay_start: cover property (@(posedge clk_sys) disable iff (!rst_n) timerBusy ##1 timerExpire);
  c_queue_step:  cover property (@(posedge clk_sys) disable iff (!rst_n) intStart && queueEn);
  c_irq:         cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(irq));

endmodule : start_sync

/* File: verification/sync_peer.sv */
// Peer controller model sharing the sync pin with the block.
// Assumes the block drives the pin only while its enable is high.
`timescale 1ns/1ps
module sync_peer (
  input  wire logic clk_sys,  // System clock
  input  wire logic startOut, // Block pin level
  input  wire logic startOe,  // Block pin enable
  input  wire logic fire,     // Send one start pulse
  input  wire logic pol,      // Active level of the pin
  output logic      pin       // Resolved pin level
);
  logic [2:0] hold_q = 3'h0; // Active cycles left
  // Pulse held four cycles so an input filter still sees it
  always_ff @(posedge clk_sys)
  begin
    if (fire)
      hold_q <= 3'h4;
    else if (hold_q != 3'h0)
      hold_q <= hold_q - 3'h1;
  end
  // Enabled party sets the wire; the peer idles at the inactive level
  assign pin = startOe ? startOut : ((hold_q != 3'h0) ? pol : ~pol);
endmodule : sync_peer

/* File: verification/ramp_start_sync_and_target_queue_bench.sv */
// Self-checking bench for the start synchroniser and target queue.
// Assumes the APB slave answers with no wait states but waits anyway.
`timescale 1ns/1ps
module ramp_start_sync_and_target_queue_bench;
  logic clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic targetArrived = 1'b0, fire = 1'b0, pslverr, pready, startOut, startOe;
  logic startIn, rampStart, irq, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, targetPosition, velocityLimit, d, t, v, eT, eV;
  logic [31:0] q [8];
  logic [31:0] actPos = 32'h0; // Actual position seen by the compare unit
  logic [2:0] rampProfile, pr, eP;
  int errCount = 0, nChecks = 0, starts = 0, n, len;
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (rampStart === 1'b1) starts++;
  start_sync u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .startIn(startIn), .startOut(startOut), .startOe(startOe),
    .targetArrived(targetArrived), .speedArrived(1'b0), .actualPosition(actPos),
    .comparePosition(32'h1), .targetPosition(targetPosition), .velocityLimit(velocityLimit),
    .rampProfile(rampProfile), .rampStart(rampStart), .irq(irq));
  sync_peer u_peer (.clk_sys(clk_sys), .startOut(startOut), .startOe(startOe), .fire(fire),
    .pol(1'b1), .pin(startIn));
  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      errCount++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer; data and error taken at the edge that sees pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    d = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic arrive;
    @(posedge clk_sys) targetArrived <= 1'b1;
    @(posedge clk_sys) targetArrived <= 1'b0;
  endtask : arrive
  // Bounded wait for a ramp start, returning cycles spent
  task automatic waitStart;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (rampStart !== 1'b1 && n < 200);
  endtask : waitStart
  task automatic close_out;
    if (errCount == 0 && nChecks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  // ==========================================================================
  // Watchdog: whole run needs a few hundred cycles
  // ==========================================================================
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    errCount++;
    close_out();
  end
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    void'($urandom(32'h37DA));
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk({startOe, startOut, irq}, 32'h6);
    eT = $urandom;
    apb(1'b1, start_sync_pkg::OFS_TARGET, eT);
    @(posedge clk_sys);
    chk(targetPosition, eT);
    eV = 32'h0; eP = 3'h0;
    // Deferred target, velocity and profile; extension 0 then 2
    for (int k = 0; k < 2; k++)
    begin
      t = $urandom; v = $urandom; pr = 3'($urandom);
      apb(1'b1, start_sync_pkg::OFS_OUT_ADD, 32'(k * 2));
      apb(1'b1, start_sync_pkg::OFS_START_DELAY, 32'h3);
      apb(1'b1, start_sync_pkg::OFS_START_CONF, 32'h247);
      apb(1'b1, start_sync_pkg::OFS_TARGET, t);
      apb(1'b1, start_sync_pkg::OFS_VEL_LIMIT, v);
      apb(1'b1, start_sync_pkg::OFS_PROFILE, 32'(pr));
      @(posedge clk_sys);
      chk(targetPosition, eT);
      chk(velocityLimit, eV);
      chk(32'(rampProfile), 32'(eP));
      arrive();
      waitStart();
      eT = t; eV = v; eP = pr;
      chk(32'(n >= 3 && n <= 5), 32'h1);
      chk(targetPosition, eT);
      chk(velocityLimit, eV);
      chk(32'(rampProfile), 32'(eP));
      len = 0;
      while (startOut === 1'b1 && len < 50)
      begin
        len++;
        @(posedge clk_sys);
      end
      chk(32'(len), 32'(k * 2 + 1));
      n = starts;
      arrive();
      repeat (12) @(posedge clk_sys);
      chk(32'(starts), 32'(n));
    end
    // Sticky start flag, mask, clear by writing one
    apb(1'b0, start_sync_pkg::OFS_IRQ_STATUS, 32'h0);
    chk(d, 32'h1);
    apb(1'b1, start_sync_pkg::OFS_IRQ_MASK, 32'h1);
    @(posedge clk_sys);
    chk(32'(irq), 32'h1);
    apb(1'b1, start_sync_pkg::OFS_IRQ_STATUS, 32'h1);
    @(posedge clk_sys);
    chk(32'(irq), 32'h0);
    // Prioritised external start must skip a long delay
    apb(1'b1, start_sync_pkg::OFS_START_DELAY, 32'd50);
    apb(1'b1, start_sync_pkg::OFS_START_CONF, 32'h621);
    t = $urandom;
    apb(1'b1, start_sync_pkg::OFS_TARGET, t);
    @(posedge clk_sys) fire <= 1'b1;
    @(posedge clk_sys) fire <= 1'b0;
    waitStart();
    chk(32'(n <= 6), 32'h1);
    chk(targetPosition, t);
    chk(32'(startOe), 32'h0);
    eT = t;
    // Queue filled and mask set before it is enabled
    for (int i = 0; i < 8; i++)
    begin
      q[i] = $urandom;
      apb(1'b1, start_sync_pkg::OFS_QUEUE_BASE + 12'(i * 4), q[i]);
    end
    apb(1'b1, start_sync_pkg::OFS_WB_MASK, 32'h10);
    apb(1'b1, start_sync_pkg::OFS_START_DELAY, 32'h2);
    apb(1'b1, start_sync_pkg::OFS_START_CONF, 32'hA41);
    arrive();
    waitStart();
    chk(targetPosition, q[0]);
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b0, start_sync_pkg::OFS_QUEUE_BASE + 12'(i * 4), 32'h0);
      chk(d, (i == 4) ? eT : q[(i < 7) ? i + 1 : 7]);
    end
    // Compare-launched delay of 20 ignores a later external pulse
    apb(1'b1, start_sync_pkg::OFS_START_DELAY, 32'd20);
    apb(1'b1, start_sync_pkg::OFS_START_CONF, 32'h321);
    t = $urandom;
    apb(1'b1, start_sync_pkg::OFS_TARGET, t);
    @(posedge clk_sys) actPos <= 32'h1;
    @(posedge clk_sys) fire <= 1'b1;
    @(posedge clk_sys) fire <= 1'b0;
    waitStart();
    chk(32'(n), 32'd20);
    chk(targetPosition, t);
    // External-launched delay ignores a later compare match
    actPos <= 32'h0;
    t = $urandom;
    apb(1'b1, start_sync_pkg::OFS_TARGET, t);
    @(posedge clk_sys) fire <= 1'b1;
    @(posedge clk_sys) fire <= 1'b0;
    @(posedge clk_sys) actPos <= 32'h1;
    waitStart();
    chk(32'(n), 32'd21);
    chk(targetPosition, t);
    apb(1'b0, 12'h100, 32'h0);
    chk(32'(e), 32'h1);
    chk(d, 32'h0);
    close_out();
  end
endmodule : ramp_start_sync_and_target_queue_bench
